// >>> rtl/event_queue_pkg.sv
// constants shared by the monitor event queue writer
package event_queue_pkg;
    // register byte offsets
    localparam logic [11:0] ctrl_offset = 12'h000;
    localparam logic [11:0] base_offset = 12'h004;
    localparam logic [11:0] size_offset = 12'h008;
    localparam logic [11:0] status_offset = 12'h00c;
    localparam logic [11:0] mask_offset = 12'h010;
    localparam logic [11:0] wptr_offset = 12'h014;
    localparam logic [11:0] stamp_offset = 12'h018;
    // control register fields
    localparam int ctrl_enable_bit = 0;
    localparam int ctrl_stamp_bit = 1;
    // interrupt register fields
    localparam int irq_overflow_bit = 0;
    localparam int irq_written_bit = 1;
    localparam logic [1:0] irq_bits_mask = 2'h3;
    // first entry word fields
    localparam int owned_bit = 15;
    localparam int port_bit = 11;
    localparam int chan_lsb = 8;
    localparam int odd_bit = 3;
    localparam int abort_bit = 2;
    localparam int first_bit = 1;
    localparam int last_bit = 0;
    // entry lengths in words
    localparam logic [15:0] entry_len_plain = 16'h0002;
    localparam logic [15:0] entry_len_stamp = 16'h0004;
    // reset values, fill patterns and step sizes
    localparam logic [15:0] size_reset = 16'h0040;
    localparam logic [23:0] base_reset = 24'h000000;
    localparam logic [7:0] byte_all_ones = 8'hff;
    localparam logic [15:0] word_zero = 16'h0000;
    localparam logic [15:0] stamp_step = 16'h0001;
    localparam logic [23:0] addr_step = 24'h000001;
    // entry word index within an entry
    localparam logic [1:0] word_status = 2'h0;
    localparam logic [1:0] word_data = 2'h1;
    localparam logic [1:0] word_stamp = 2'h2;
    localparam logic [1:0] word_pad = 2'h3;
endpackage : event_queue_pkg

// >>> rtl/double_byte_filter.sv
// accepts a received byte once it repeats identically, or at once in single mode
`timescale 1ns/1ps
module double_byte_filter
    import event_queue_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic byte_valid,
    input wire logic [7:0] byte_data,
    input wire logic single_mode,
    output logic accept,
    output logic [7:0] accept_data
);
    logic [7:0] prev_reg;
    logic have_reg;
    wire same = have_reg && (prev_reg == byte_data);
    // single-byte protocol takes each byte at once
    assign accept = byte_valid && (single_mode || same);
    assign accept_data = byte_data;
    // remember last byte; a match consumes the pair
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            prev_reg <= 8'h00;
            have_reg <= 1'b0;
        end
        else if (byte_valid)
        begin
            prev_reg <= byte_data;
            have_reg <= !same;
        end
    end
endmodule : double_byte_filter

// >>> rtl/stamp_counter.sv
// free-running binary timestamp counter
`timescale 1ns/1ps
module stamp_counter
    import event_queue_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    output logic [15:0] count
);
    logic [15:0] count_reg;
    assign count = count_reg;
    // wraps silently; software sees only relative time
    always_ff @(posedge clk)
    begin
        if (rst)
            count_reg <= word_zero;
        else
            count_reg <= count_reg + stamp_step;
    end
endmodule : stamp_counter

// >>> rtl/monitor_event_queue_writer.sv
// monitor event queue writer with apb registers and memory master
`timescale 1ns/1ps
module monitor_event_queue_writer
    import event_queue_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rx_byte_valid,
    input wire logic [7:0] rx_byte,
    input wire logic rx_port,
    input wire logic [2:0] rx_channel,
    input wire logic rx_msg_first,
    input wire logic rx_msg_end,
    input wire logic rx_msg_abort,
    input wire logic rx_single_mode,
    output logic rx_ready,
    output logic mem_req,
    output logic mem_write,
    output logic [23:0] mem_addr,
    output logic [15:0] mem_wdata,
    input wire logic [15:0] mem_rdata,
    input wire logic mem_ack,
    output logic irq
);
    typedef enum {idle, pend, rd_own, wr_words, done} state_type;
    state_type state_reg, state_next;
    logic [1:0] ctrl_reg;
    logic [23:0] base_reg;
    logic [15:0] size_reg, wptr_reg;
    logic [1:0] status_reg, mask_reg;
    logic [31:0] prdata_reg;
    logic pready_reg, pslverr_reg, irq_reg;
    logic req_reg, write_reg, ready_reg;
    logic [23:0] addr_reg;
    logic [15:0] wdata_reg;
    logic [1:0] word_reg;
    logic [7:0] low_reg, high_reg;
    logic have_low_reg, first_reg, last_reg, abort_reg, odd_reg;
    logic port_reg, single_reg;
    logic [2:0] chan_reg;
    logic [15:0] stamp_reg;
    logic overflow_set, written_set;
    logic accept;
    logic [7:0] accept_data;
    logic [15:0] stamp_now;

    double_byte_filter filter_u (
        .clk(clk),
        .rst(rst),
        .byte_valid(rx_byte_valid && ready_reg),
        .byte_data(rx_byte),
        .single_mode(rx_single_mode),
        .accept(accept),
        .accept_data(accept_data)
    );

    stamp_counter stamp_u (
        .clk(clk),
        .rst(rst),
        .count(stamp_now)
    );

    function automatic logic [15:0] status_word(
        input logic port, input logic [2:0] chan, input logic odd,
        input logic abrt, input logic first, input logic last);
        logic [15:0] w;
        w = word_zero;
        w[owned_bit] = 1'b1;
        w[port_bit] = port;
        w[chan_lsb +: 3] = chan;
        w[odd_bit] = odd;
        w[abort_bit] = abrt;
        w[first_bit] = first;
        w[last_bit] = last;
        return w;
    endfunction : status_word

    // apb decode; zero wait states
    wire apb_setup = psel && !penable;
    wire apb_wr = apb_setup && pwrite;
    wire hit_ctrl = paddr == ctrl_offset;
    wire hit_base = paddr == base_offset;
    wire hit_size = paddr == size_offset;
    wire hit_status = paddr == status_offset;
    wire hit_mask = paddr == mask_offset;
    wire hit_wptr = paddr == wptr_offset;
    wire hit_stamp = paddr == stamp_offset;
    wire mapped = hit_ctrl || hit_base || hit_size || hit_status
        || hit_mask || hit_wptr || hit_stamp;
    wire enabled = ctrl_reg[ctrl_enable_bit];
    wire stamping = ctrl_reg[ctrl_stamp_bit];
    wire [1:0] w1c = (apb_wr && hit_status) ? pwdata[1:0] : 2'h0;
    wire [31:0] rd_mux =
        hit_ctrl ? {30'h0, ctrl_reg} :
        hit_base ? {8'h00, base_reg} :
        hit_size ? {16'h0000, size_reg} :
        hit_status ? {30'h0, status_reg} :
        hit_mask ? {30'h0, mask_reg} :
        hit_wptr ? {16'h0000, wptr_reg} :
        hit_stamp ? {16'h0000, stamp_now} : 32'h0;

    // entry assembly helpers
    wire [15:0] entry_len = stamping ? entry_len_stamp : entry_len_plain;
    wire [1:0] last_word = stamping ? word_pad : word_data;
    // an entry that would cross the end starts at the base
    wire [15:0] wptr_start = (wptr_reg + entry_len > size_reg) ? word_zero
        : wptr_reg;
    wire [15:0] wptr_adv = wptr_start + entry_len;
    wire [15:0] wptr_wrap = (wptr_adv >= size_reg) ? word_zero : wptr_adv;
    wire [23:0] slot_addr = base_reg + {8'h00, wptr_start};
    wire mem_done = req_reg && mem_ack;
    wire odd_flag = single_reg ? 1'b1 : odd_reg;
    wire abort_flag = single_reg ? 1'b0 : abort_reg;
    wire first_flag = single_reg ? 1'b1 : first_reg;
    // single-byte entries always carry last
    // other entries carry last when the message end came with their final byte
    wire last_flag = single_reg ? 1'b1 : last_reg;
    // port select from the reporting serial port
    wire [15:0] status_w = status_word(port_reg, chan_reg, odd_flag,
        abort_flag, first_flag, last_flag);
    // high byte all ones when single
    wire [15:0] data_w = single_reg ? {byte_all_ones, low_reg}
        : {high_reg, low_reg};
    // timestamp captured at event
    // word loaded next: the top word after the check, then one lower
    wire [1:0] fill_word = (state_reg == rd_own) ? last_word
        : word_reg - 2'h1;
    wire [15:0] word_mux = (fill_word == word_data) ? data_w :
        (fill_word == word_stamp) ? stamp_reg :
        (fill_word == word_pad) ? word_zero : status_w;
    // a pair closes on second byte; end or abort flushes one
    wire pair_full = accept && (have_low_reg || rx_single_mode);
    // a lone byte that ends or aborts the message goes out at once
    wire flush = accept && !pair_full && (rx_msg_end || rx_msg_abort);

    // next state of the entry writer
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            idle:
                if (pair_full || flush)
                    state_next = pend;
            pend:
                state_next = rd_own;
            rd_own:
                if (mem_done)
                    state_next = mem_rdata[owned_bit] ? done : wr_words;
            wr_words:
                if (mem_done && word_reg == word_status)
                    state_next = done;
            done:
                state_next = idle;
            default:
                state_next = idle;
        endcase
    end

    assign overflow_set = state_reg == rd_own && mem_done
        && mem_rdata[owned_bit];
    assign written_set = state_reg == wr_words && mem_done
        && word_reg == word_status;

    // apb slave and interrupt logic; set wins over clear
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            ctrl_reg <= 2'h0;
            base_reg <= base_reset;
            size_reg <= size_reset;
            mask_reg <= 2'h0;
            status_reg <= 2'h0;
            prdata_reg <= 32'h0;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            irq_reg <= 1'b0;
        end
        else
        begin
            if (apb_wr && hit_ctrl)
                ctrl_reg <= pwdata[1:0];
            if (apb_wr && hit_base)
                base_reg <= pwdata[23:0];
            if (apb_wr && hit_size)
                size_reg <= pwdata[15:0];
            if (apb_wr && hit_mask)
                mask_reg <= pwdata[1:0] & irq_bits_mask;
            status_reg <= (status_reg & ~w1c)
                | {written_set, overflow_set};
            prdata_reg <= apb_setup && !pwrite ? rd_mux : 32'h0;
            pready_reg <= apb_setup;
            pslverr_reg <= apb_setup && !mapped;
            irq_reg <= |(status_reg & mask_reg);
        end
    end

    // byte collection and entry capture
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            have_low_reg <= 1'b0;
            low_reg <= 8'h00;
            high_reg <= 8'h00;
            first_reg <= 1'b0;
            last_reg <= 1'b0;
            abort_reg <= 1'b0;
            odd_reg <= 1'b0;
            port_reg <= 1'b0;
            chan_reg <= 3'h0;
            single_reg <= 1'b0;
            stamp_reg <= word_zero;
            ready_reg <= 1'b0;
        end
        else if (state_reg == idle)
        begin
            // collection pauses while an entry is being written
            ready_reg <= enabled && !(pair_full || flush);
            if (accept && !pair_full)
            begin
                have_low_reg <= 1'b1;
                low_reg <= accept_data;
                first_reg <= rx_msg_first;
                port_reg <= rx_port;
                chan_reg <= rx_channel;
                stamp_reg <= stamp_now;
            end
            if (pair_full)
            begin
                have_low_reg <= 1'b0;
                single_reg <= rx_single_mode;
                odd_reg <= rx_single_mode;
                if (rx_single_mode)
                begin
                    low_reg <= accept_data;
                    port_reg <= rx_port;
                    chan_reg <= rx_channel;
                end
                else
                    high_reg <= accept_data;
                last_reg <= rx_msg_end;
                abort_reg <= rx_msg_abort;
                stamp_reg <= stamp_now;
            end
            if (flush)
            begin
                have_low_reg <= 1'b0;
                single_reg <= 1'b0;
                odd_reg <= 1'b1;
                high_reg <= 8'h00;
                last_reg <= rx_msg_end;
                abort_reg <= rx_msg_abort;
            end
        end
        else
        begin
            ready_reg <= 1'b0;
            if (state_reg == done)
                first_reg <= 1'b0;
        end
    end

    // memory master: one word per handshake, status word last
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_reg <= idle;
            req_reg <= 1'b0;
            write_reg <= 1'b0;
            addr_reg <= base_reset;
            wdata_reg <= word_zero;
            word_reg <= word_status;
            wptr_reg <= word_zero;
        end
        else
        begin
            state_reg <= state_next;
            if (apb_wr && hit_size)
                wptr_reg <= word_zero;
            if (state_reg == pend)
            begin
                req_reg <= 1'b1;
                write_reg <= 1'b0;
                addr_reg <= slot_addr;
            end
            if (state_reg == rd_own && mem_done && !mem_rdata[owned_bit])
            begin
                // status word written last, sets ownership
                word_reg <= last_word;
                addr_reg <= slot_addr + {22'h0, last_word};
                write_reg <= 1'b1;
                wdata_reg <= word_mux;
            end
            else if (state_reg == rd_own && mem_done)
                req_reg <= 1'b0;
            if (state_reg == wr_words && mem_done)
            begin
                if (word_reg == word_status)
                begin
                    req_reg <= 1'b0;
                    write_reg <= 1'b0;
                    wptr_reg <= wptr_wrap;
                end
                else
                begin
                    word_reg <= word_reg - 2'h1;
                    addr_reg <= addr_reg - addr_step;
                    wdata_reg <= word_mux;
                end
            end
        end
    end

    // outputs straight from flip-flops
    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign irq = irq_reg;
    assign rx_ready = ready_reg;
    assign mem_req = req_reg;
    assign mem_write = write_reg;
    assign mem_addr = addr_reg;
    assign mem_wdata = wdata_reg;
endmodule : monitor_event_queue_writer

// >>> sim/event_queue_writer_assertions.sv
// concurrent checks on the event queue writer ports
`timescale 1ns/1ps
module event_queue_writer_assertions
    import event_queue_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic mem_req,
    input wire logic mem_write,
    input wire logic [23:0] mem_addr,
    input wire logic [15:0] mem_wdata,
    input wire logic [15:0] mem_rdata,
    input wire logic mem_ack
);
    logic read_ok;
    logic [23:0] slot_addr;
    logic [23:0] base_v;
    logic [15:0] size_v;
    wire apb_wr = psel && penable && pready && pwrite;
    wire wr_cyc = mem_req && mem_write;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    // last slot check result and the programmed queue window
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            read_ok <= 1'b0;
            slot_addr <= 24'h000000;
            base_v <= base_reset;
            size_v <= size_reset;
        end
        else
        begin
            if (mem_ack && !mem_write)
                read_ok <= !mem_rdata[owned_bit];
            else if (mem_ack && mem_addr == slot_addr)
                read_ok <= 1'b0;
            if (mem_ack && !mem_write)
                slot_addr <= mem_addr;
            if (apb_wr && paddr == base_offset)
                base_v <= pwdata[23:0];
            if (apb_wr && paddr == size_offset)
                size_v <= pwdata[15:0];
        end
    end
    AST_READ_FIRST:
        assert property (wr_cyc |-> read_ok)
        else $error("entry write without a free slot check");
    AST_OWNED_SET:
        assert property (wr_cyc && mem_addr == slot_addr
            |-> mem_wdata[owned_bit])
        else $error("status word written without ownership bit");
    AST_OWNED_SKIP:
        assert property (mem_ack && !mem_write && mem_rdata[owned_bit]
            |=> !mem_req)
        else $error("owned slot not left alone");
    AST_HOLD_REQ:
        assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr)
            && $stable(mem_wdata) && $stable(mem_write))
        else $error("memory request changed before ack");
    AST_STATUS_LAST:
        assert property (mem_ack && mem_write && mem_addr == slot_addr
            |=> !mem_req)
        else $error("access after the status word");
    AST_PAD_ZERO:
        assert property (wr_cyc && mem_addr == slot_addr + 24'h3
            |-> mem_wdata == word_zero)
        else $error("fourth entry word not zero");
    AST_IN_QUEUE:
        assert property (mem_req |-> mem_addr - base_v < {8'h00, size_v})
        else $error("memory access outside the queue");
    AST_APB_READY:
        assert property (psel && !penable |=> pready)
        else $error("register access not answered in time");
    AST_APB_ERR:
        assert property (psel && penable && pready && paddr > stamp_offset
            |-> pslverr)
        else $error("unmapped register access not refused");
    // main scenarios reached
    cover property (mem_ack && !mem_write && mem_rdata[owned_bit]);
    cover property (wr_cyc && mem_addr == slot_addr + 24'h3);
    cover property (pready && pslverr);
endmodule : event_queue_writer_assertions

// >>> sim/shared_memory_model.sv
// shared memory answering the writer's word requests
`timescale 1ns/1ps
module shared_memory_model
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [3:0] ack_delay,
    input wire logic mem_req,
    input wire logic mem_write,
    input wire logic [23:0] mem_addr,
    input wire logic [15:0] mem_wdata,
    output logic [15:0] mem_rdata,
    output logic mem_ack
);
    logic [15:0] ram [0:255];
    logic [3:0] waited = 4'h0;
    initial
    begin
        mem_ack = 1'b0;
        mem_rdata = 16'h5a5a;
        for (int i = 0; i < 256; i++)
            ram[i] = 16'h0000;
    end
    // slow answers on demand; read data scrambles when not valid
    always @(posedge clk)
    begin
        mem_ack <= 1'b0;
        mem_rdata <= ~mem_rdata;
        if (rst)
            waited <= 4'h0;
        else if (mem_req && !mem_ack && waited != ack_delay)
            waited <= waited + 4'h1;
        else if (mem_req && !mem_ack)
        begin
            waited <= 4'h0;
            mem_ack <= 1'b1;
            if (mem_write)
                ram[mem_addr[7:0]] <= mem_wdata;
            else
                mem_rdata <= ram[mem_addr[7:0]];
        end
    end
endmodule : shared_memory_model

// >>> sim/tb_top.sv
// testbench for the monitor event queue writer
`timescale 1ns/1ps
module tb_top;
    import event_queue_pkg::*;
    logic clk, rst, psel, penable, pwrite, pready, pslverr, irq, rerr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdata;
    logic rx_byte_valid, rx_port, rx_msg_first, rx_msg_end, rx_msg_abort;
    logic rx_single_mode, rx_ready, mem_req, mem_write, mem_ack;
    logic [7:0] rx_byte;
    logic [2:0] rx_channel;
    logic [23:0] mem_addr;
    logic [15:0] mem_wdata, mem_rdata, t0;
    logic [3:0] ack_delay;
    int n_fail = 0;
    int checked = 0;
    monitor_event_queue_writer DUT (.*);
    shared_memory_model MEM (.*);
    task automatic chk(input string what, input logic [31:0] e,
        input logic [31:0] g);
        checked++;
        if (g !== e)
        begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask : chk
    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a,
        input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
            @(posedge clk);
        while (pready !== 1'b1);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk("register", e, rdata);
    endtask : rd
    // q packs single, abort, end, first, port, channel
    task automatic offer(input logic [7:0] b, input logic [7:0] q);
        int n;
        n = 0;
        rx_byte_valid <= 1'b1;
        rx_byte <= b;
        {rx_single_mode, rx_msg_abort, rx_msg_end, rx_msg_first, rx_port,
            rx_channel} <= q;
        do
            @(posedge clk);
        while (rx_ready !== 1'b1 && ++n < 300);
        if (n == 300)
            n_fail++;
        rx_byte_valid <= 1'b0;
        @(posedge clk);
    endtask : offer
    task automatic wait_own(input int i);
        int n;
        n = 0;
        while ((MEM.ram[i][owned_bit] !== 1'b1 || rx_ready !== 1'b1)
            && n < 300)
        begin
            @(posedge clk);
            n++;
        end
        if (n == 300)
            n_fail++;
    endtask : wait_own
    task automatic t_regs;
        rd(size_offset, 32'h40);
        rd(ctrl_offset, 32'h0);
        apb(1'b1, base_offset, 32'h10);
        apb(1'b1, size_offset, 32'h8);
        rd(size_offset, 32'h8);
        rd(12'h01c, 32'h0);
        chk("slverr", 32'h1, {31'h0, rerr});
    endtask : t_regs
    // an unrepeated byte is dropped before the pair
    task automatic t_pair;
        apb(1'b1, ctrl_offset, 32'h1);
        offer(8'h99, 8'h1d);
        offer(8'h12, 8'h1d);
        offer(8'h12, 8'h1d);
        offer(8'h34, 8'h2d);
        offer(8'h34, 8'h2d);
        wait_own(16);
        chk("status", 32'h8d03, MEM.ram[16]);
        chk("data", 32'h3412, MEM.ram[17]);
        rd(wptr_offset, 32'h2);
    endtask : t_pair
    task automatic t_odd_abort;
        ack_delay <= 4'h3;
        offer(8'h9a, 8'h73);
        offer(8'h9a, 8'h73);
        wait_own(18);
        chk("status", 32'h830f, MEM.ram[18]);
        chk("low", 32'h9a, MEM.ram[19][7:0]);
    endtask : t_odd_abort
    task automatic t_single;
        offer(8'h5c, 8'h82);
        wait_own(20);
        chk("status", 32'h820b, MEM.ram[20]);
        chk("data", 32'hff5c, MEM.ram[21]);
        rd(wptr_offset, 32'h6);
    endtask : t_single
    // processor hands every slot back, then a stamped entry
    task automatic t_timed;
        logic [15:0] s;
        logic in_win;
        for (int i = 16; i < 24; i++)
            MEM.ram[i] = 16'h0000;
        apb(1'b1, size_offset, 32'h8);
        apb(1'b1, ctrl_offset, 32'h3);
        apb(1'b0, stamp_offset, 32'h0);
        t0 = rdata[15:0];
        offer(8'h41, 8'h1f);
        offer(8'h41, 8'h1f);
        offer(8'h42, 8'h2f);
        offer(8'h42, 8'h2f);
        wait_own(16);
        s = MEM.ram[18];
        apb(1'b0, stamp_offset, 32'h0);
        chk("status", 32'h8f03, MEM.ram[16]);
        chk("data", 32'h4241, MEM.ram[17]);
        in_win = s - t0 <= rdata[15:0] - t0 && s != t0;
        chk("stamp", 32'h1, {31'h0, in_win});
        chk("pad", 32'h0, MEM.ram[19]);
        rd(wptr_offset, 32'h4);
    endtask : t_timed
    task automatic t_overflow;
        int n;
        n = 0;
        MEM.ram[20] = 16'h8000;
        offer(8'h66, 8'h80);
        do
            apb(1'b0, status_offset, 32'h0);
        while (rdata[irq_overflow_bit] !== 1'b1 && ++n < 40);
        chk("overflow", 32'h1, {31'h0, rdata[irq_overflow_bit]});
        chk("irq masked", 32'h0, {31'h0, irq});
        chk("kept", 32'h0, MEM.ram[21]);
        apb(1'b1, mask_offset, 32'h1);
        chk("irq", 32'h1, {31'h0, irq});
        apb(1'b1, status_offset, 32'h1);
        chk("irq clear", 32'h0, {31'h0, irq});
        rd(status_offset, 32'h2);
        MEM.ram[20] = 16'h0000;
        offer(8'h66, 8'h80);
        wait_own(20);
        chk("status", 32'h800b, MEM.ram[20]);
        chk("data", 32'hff66, MEM.ram[21]);
        rd(wptr_offset, 32'h0);
    endtask : t_overflow
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : conclude
    initial
    begin
        clk = 1'b0;
        forever
            #12.5 clk = ~clk;
    end
    // reset, then the scenarios in pointer order
    initial
    begin
        {rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 47'h0};
        {rx_byte_valid, rx_byte, rx_port, rx_channel} = 13'h0;
        {rx_msg_first, rx_msg_end, rx_msg_abort, rx_single_mode} = 4'h0;
        ack_delay = 4'h0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_pair();
        t_odd_abort();
        t_single();
        t_timed();
        t_overflow();
        conclude();
    end
    // watchdog well beyond the few hundred cycles needed
    initial
    begin
        #300000;
        n_fail++;
        conclude();
    end
endmodule : tb_top
bind monitor_event_queue_writer event_queue_writer_assertions CHK (.*);
